// ==== design/hsg_pkg.sv ====
// Package: constants and types of the harmonic search and gate doubler
package hsg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STRETCH_MS     = 3;
  // Least time, rounded up to whole cycles
  localparam int STRETCH_CYCLES =
    (STRETCH_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_DELAY_US   = 10;
  localparam int DIV_CYCLES     =
    (DIV_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRETCH_W      = 20;

  // ----------------------------------------------------------------
  // Scan counter
  // ----------------------------------------------------------------
  localparam logic [3:0] SCAN_LAST  = 4'h9;
  localparam logic [3:0] SCAN_FIRST = 4'h0;

  // ----------------------------------------------------------------
  // Register map (word indices on the bus, not byte addresses)
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_STATUS  = 2'h1;
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam int CTRL_DIV_BIT    = 0;
  localparam int CTRL_MAN_BIT    = 1;
  localparam int CTRL_IDX_LSB    = 4;
  localparam int STAT_IDX_LSB    = 0;
  localparam int STAT_BEAT_BIT   = 4;
  localparam int STAT_GATE_BIT   = 5;
  localparam int STAT_STRETCH_BIT = 6;
  localparam int STAT_SCAN_BIT   = 7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] manualIndex;
    logic [1:0] spare;
    logic       manualMode;
    logic       dividerMode;
  } hsg_ctrl_t;

  // Counter-side inputs, sampled together
  typedef struct packed {
    logic resetPulse;
    logic gateInterval;
    logic scanTick;
    logic pluginSelected;
    logic comparatorOut_n;
  } hsg_pins_t;

  // Synchroniser reset: every pin at its idle level, comparator high
  localparam hsg_pins_t PINS_RST = '{comparatorOut_n: 1'b1, default: 1'b0};

endpackage : hsg_pkg

// ==== design/hsg_gate_doubler.sv ====
// Harmonic scan sequencer and gate doubler with Avalon-MM registers
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module hsg_gate_doubler #(
  parameter int STRETCH_LEN = hsg_pkg::STRETCH_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [1:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // From the counter and the comparator (asynchronous pins)
  input  wire logic        resetPulse,
  input  wire logic        gateInterval,
  input  wire logic        scanTick,
  input  wire logic        pluginSelected,
  input  wire logic        comparatorOut_n,
  // To the counter
  output logic             doubledGate,
  output logic      [3:0]  harmonicIndex
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  hsg_pkg::hsg_pins_t pinMeta;
  hsg_pkg::hsg_pins_t pinSync;
  logic               tickLast;
  logic               intervalLast;
  hsg_pkg::hsg_pins_t pinRaw;

  assign pinRaw = '{resetPulse:      resetPulse,
                    gateInterval:    gateInterval,
                    scanTick:        scanTick,
                    pluginSelected:  pluginSelected,
                    comparatorOut_n: comparatorOut_n};

  // Two stages; the first is read by the second only
  // Idle levels after reset, so no false beat-found follows reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta <= hsg_pkg::PINS_RST;
      pinSync <= hsg_pkg::PINS_RST;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  // Edge history taken from the synchronised stage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tickLast     <= 1'b0;
      intervalLast <= 1'b0;
    end else begin
      tickLast     <= pinSync.scanTick;
      intervalLast <= pinSync.gateInterval;
    end
  end

  // ----------------------------------------------------------------
  // Control register and decoded conditions
  // ----------------------------------------------------------------
  hsg_pkg::hsg_ctrl_t control;
  logic               clearCycle;
  logic               tickEdge;
  logic               intervalEdge;
  logic               beatFound;
  logic               scanEnable;
  logic [3:0]         scanCount;
  logic [3:0]         next_scanCount;
  logic [3:0]         selectedIndex;

  assign clearCycle   = pinSync.resetPulse;
  assign tickEdge     = pinSync.scanTick & ~tickLast;
  // Only rising edges of the interval may toggle the gate
  assign intervalEdge = pinSync.gateInterval & ~intervalLast;

  // comparator low means a usable beat
  assign beatFound = ~pinSync.comparatorOut_n | control.dividerMode;

  assign scanEnable = ~beatFound & ~control.dividerMode &
                      ~control.manualMode & pinSync.pluginSelected;

  assign next_scanCount = (scanCount == hsg_pkg::SCAN_LAST) ?
                          hsg_pkg::SCAN_FIRST : scanCount + 4'h1;

  // manual setting replaces the scan output
  assign selectedIndex = control.manualMode ?
                         control.manualIndex : scanCount;

  // ----------------------------------------------------------------
  // Scan counter
  // ----------------------------------------------------------------
  // cleared by the reset pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scanCount <= hsg_pkg::SCAN_FIRST;
    end else if (clearCycle) begin
      scanCount <= hsg_pkg::SCAN_FIRST;
    end else if (tickEdge && scanEnable) begin
      scanCount <= next_scanCount;
    end
  end

  // ----------------------------------------------------------------
  // Reset stretch one-shot
  // ----------------------------------------------------------------
  logic [hsg_pkg::STRETCH_W-1:0] stretchCount;
  logic [hsg_pkg::STRETCH_W-1:0] stretchLoad;
  logic                          stretching;

  // divider mode uses the short fixed delay
  assign stretchLoad = control.dividerMode ?
                       hsg_pkg::STRETCH_W'(hsg_pkg::DIV_CYCLES) :
                       hsg_pkg::STRETCH_W'(STRETCH_LEN);
  assign stretching  = clearCycle | (stretchCount != '0);

  // counts down from the release of the reset pulse
  // gate flop is held while this runs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stretchCount <= '0;
    end else if (clearCycle) begin
      stretchCount <= stretchLoad;
    end else if (stretchCount != '0) begin
      stretchCount <= stretchCount - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Gate doubling JK flop (J = K = beat-found)
  // ----------------------------------------------------------------
  logic gateToggle;

  // with J low the flop stays put
  assign gateToggle = beatFound & intervalEdge;

  // toggling on rising edges spans two intervals
  // divider mode keeps this running on interval edges without a comparator beat
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      doubledGate <= 1'b0;
    end else if (stretching) begin
      doubledGate <= 1'b0;
    end else if (gateToggle) begin
      doubledGate <= ~doubledGate;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      harmonicIndex <= hsg_pkg::SCAN_FIRST;
    end else begin
      harmonicIndex <= selectedIndex;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait state per access
  // ----------------------------------------------------------------
  logic        request;
  logic        accept;
  logic [31:0] statusWord;
  logic [31:0] readMux;

  assign request = read | write;
  // Transfer completes on the edge that sees waitrequest low
  assign accept  = write & ~waitrequest & (address == hsg_pkg::ADDR_CONTROL);

  assign statusWord = {24'h000000,
                       scanEnable, stretching, doubledGate, beatFound,
                       scanCount};
  // Unmapped words read as zero
  assign readMux = (address == hsg_pkg::ADDR_CONTROL) ? {24'h000000, control} :
                   (address == hsg_pkg::ADDR_STATUS)  ? statusWord :
                   32'h00000000;

  // Low for exactly one cycle after a request is seen
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~(request & waitrequest);
    end
  end

  // Read data is captured before the completing edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h00000000;
    end else if (read && waitrequest) begin
      readdata <= readMux;
    end
  end

  // Control writes; upper and spare bits ignored
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      control <= hsg_pkg::CONTROL_RST;
    end else if (accept) begin
      control.dividerMode <= writedata[hsg_pkg::CTRL_DIV_BIT];
      control.manualMode  <= writedata[hsg_pkg::CTRL_MAN_BIT];
      control.manualIndex <=
        writedata[hsg_pkg::CTRL_IDX_LSB +: 4];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  clear_cycle_a: assert property (
    clearCycle |=> (scanCount == 4'h0) && !doubledGate)
    else $error("reset pulse did not clear scan and gate");

  stretch_hold_a: assert property (
    $fell(clearCycle) && !control.dividerMode |-> !doubledGate [*8])
    else $error("gate moved during reset stretch");

  idle_nobeat_a: assert property (
    !beatFound && !stretching |=> $stable(doubledGate))
    else $error("gate flop moved with J low");

  scan_step_a: assert property (
    tickEdge && scanEnable && !clearCycle
      |=> scanCount == (($past(scanCount) == 4'h9) ? 4'h0
                        : $past(scanCount) + 4'h1))
    else $error("scan counter stepped wrongly");

  scan_freeze_a: assert property (
    beatFound && !clearCycle |=> $stable(scanCount))
    else $error("scan moved while beat present");

  gate_toggle_a: assert property (
    intervalEdge && beatFound && !stretching
      |=> doubledGate != $past(doubledGate))
    else $error("gate did not toggle on interval edge");

  divider_beat_a: assert property (
    control.dividerMode |-> beatFound && !scanEnable)
    else $error("divider mode did not force beat");

  scan_gate_a: assert property (
    (control.manualMode || !pinSync.pluginSelected) |-> !scanEnable)
    else $error("scan gate open in wrong mode");

  index_out_a: assert property (
    1'b1 |=> harmonicIndex == $past(selectedIndex))
    else $error("index output mismatch");

  divider_delay_a: assert property (
    $fell(clearCycle) && control.dividerMode
      |-> !doubledGate [*2] ##0 (stretchCount == 20'(hsg_pkg::DIV_CYCLES) - 20'd1))
    else $error("divider delay not loaded");

  gate_opens_c:   cover property ($rose(doubledGate));
  scan_wraps_c:   cover property (scanCount == 4'h9 ##[1:200] scanCount == 4'h0);
  divider_gate_c: cover property (control.dividerMode && $rose(doubledGate));
  bus_write_c:    cover property (accept);

endmodule : hsg_gate_doubler

`default_nettype wire

// ==== test/hsg_counter_model.sv ====
// Partner model: counter side with reset pulse, gate interval and tick
`timescale 1ns/10ps
`default_nettype none
module hsg_counter_model #(
  parameter int TICK_PER = 40,
  parameter int GATE_PER = 24
) (
  // Clock and bench controls
  input  wire logic clock,
  input  wire logic cycleReq,
  input  wire logic tickRun,
  input  wire logic gateRun,
  // Pins towards the block
  output wire logic resetPulse,
  output wire logic gateInterval,
  output wire logic scanTick
);
  int pulseCnt = 0;
  int tickCnt  = 0;
  int gateCnt  = 0;
  // reset, interval, tick
  // Time base runs on to zero when stopped, so lines rest low between runs
  always @(posedge clock) begin
    pulseCnt <= cycleReq ? 8 : (pulseCnt > 0 ? pulseCnt - 1 : 0);
    if (tickRun || tickCnt != 0)
      tickCnt <= (tickCnt + 1) % TICK_PER;
    if (gateRun || gateCnt != 0)
      gateCnt <= (gateCnt + 1) % GATE_PER;
  end
  assign resetPulse   = pulseCnt > 0;
  assign scanTick     = tickCnt >= 1 && tickCnt <= 4;
  assign gateInterval = gateCnt >= 1 && gateCnt <= GATE_PER / 2;
endmodule : hsg_counter_model
`default_nettype wire

// ==== test/hsg_gate_doubler_tb.sv ====
// Self-checking bench of the harmonic search gate doubler
`timescale 1ns/10ps
`default_nettype none
module hsg_gate_doubler_tb;
  localparam int TP = 40;
  localparam int GP = 24;
  localparam int SL = 50;
  localparam int DV = hsg_pkg::DIV_CYCLES;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [1:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest, doubledGate, resetPulse, gateInterval, scanTick;
  logic        pluginSelected;
  logic        comparatorOut_n;
  logic        cycleReq, tickRun, gateRun;
  logic [3:0]  harmonicIndex, idx;
  logic [31:0] rdQ[$];
  logic [4:0]  outQ[$];
  logic [4:0]  last = 5'h00;
  int          nFail = 0, checked = 0, hiCnt = 0, cyc = 0, n = 0;

  hsg_gate_doubler #(.STRETCH_LEN(SL)) dut (.clock(clock),
    .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .resetPulse(resetPulse), .gateInterval(gateInterval),
    .scanTick(scanTick), .pluginSelected(pluginSelected),
    .comparatorOut_n(comparatorOut_n), .doubledGate(doubledGate),
    .harmonicIndex(harmonicIndex));
  hsg_counter_model #(.TICK_PER(TP), .GATE_PER(GP)) partner (.clock(clock),
    .cycleReq(cycleReq), .tickRun(tickRun), .gateRun(gateRun),
    .resetPulse(resetPulse), .gateInterval(gateInterval),
    .scanTick(scanTick));

  initial begin
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      nFail++;
      $display("MISMATCH %s expected %0h seen %0h", what, e, s);
    end
  endtask : check

  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : printVerdict

  // Avalon master: hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [1:0] a,
                     input logic [31:0] d, e);
    @(posedge clock);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    if (!wr) rdQ.push_back(e);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    check("waitrequest", waitrequest, 32'h0);
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic cycle;
    @(posedge clock);
    cycleReq <= 1'b1;
    @(posedge clock);
    cycleReq <= 1'b0;
    repeat (10) @(posedge clock);
  endtask : cycle

  // Bounded waits; n keeps the cycles spent
  task automatic waitQ;
    n = 0;
    while (outQ.size() > 0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
  endtask : waitQ

  task automatic waitRise;
    n = 0;
    while (doubledGate !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
  endtask : waitRise

  task automatic endTest(input string name);
    repeat (30) @(posedge clock);
    check("pending", outQ.size(), 0);
    $display("%s finished", name);
  endtask : endTest

  // Monitor: every output change takes the oldest expectation
  always @(posedge clock) begin
    if (reset_n) begin
      if (read && !waitrequest) check("readdata", readdata, rdQ.pop_front());
      if ({doubledGate, harmonicIndex} !== last) begin
        check("outputs", {doubledGate, harmonicIndex}, outQ.size() ? outQ.pop_front() : 5'h1F);
        last <= {doubledGate, harmonicIndex};
      end
      if (doubledGate) hiCnt <= hiCnt + 1;
      else if (last[4]) begin
        check("gateWidth", hiCnt, GP);
        hiCnt <= 0;
      end
      cyc++;
      if (cyc > 30000) begin
        nFail++;
        printVerdict();
      end
    end
  end

  initial begin
    void'($urandom(85));
    address         <= 2'h0;
    read            <= 1'b0;
    write           <= 1'b0;
    writedata       <= 32'h0;
    pluginSelected  <= 1'b0;
    comparatorOut_n <= 1'b1;
    cycleReq        <= 1'b0;
    tickRun         <= 1'b0;
    gateRun         <= 1'b0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    bus(1'b0, hsg_pkg::ADDR_CONTROL, 32'h0, 32'h0);
    bus(1'b0, hsg_pkg::ADDR_STATUS, 32'h0, 32'h0);
    bus(1'b1, hsg_pkg::ADDR_STATUS, 32'hFF, 32'h0);
    bus(1'b0, hsg_pkg::ADDR_STATUS, 32'h0, 32'h0);
    bus(1'b1, 2'h2, 32'hFF, 32'h0);
    bus(1'b0, 2'h2, 32'h0, 32'h0);
    bus(1'b1, hsg_pkg::ADDR_CONTROL, 32'h50, 32'h0);
    bus(1'b0, hsg_pkg::ADDR_CONTROL, 32'h0, 32'h50);
    bus(1'b1, hsg_pkg::ADDR_CONTROL, 32'h0, 32'h0);
    endTest("registers");
    tickRun <= 1'b1;
    repeat (3 * TP) @(posedge clock);
    for (int i = 1; i <= 13; i++) outQ.push_back({1'b0, 4'(i % 10)});
    cycle();
    pluginSelected <= 1'b1;
    waitQ();
    comparatorOut_n <= 1'b0;
    outQ.push_back(5'h13);
    outQ.push_back(5'h03);
    repeat (2 * TP) @(posedge clock);
    gateRun <= 1'b1;
    waitQ();
    gateRun <= 1'b0;
    tickRun <= 1'b0;
    comparatorOut_n <= 1'b1;
    endTest("search");
    outQ.push_back(5'h00);
    comparatorOut_n <= 1'b0;
    cycle();
    outQ.push_back(5'h10);
    outQ.push_back(5'h00);
    gateRun <= 1'b1;
    waitRise();
    check("stretchDelay", n >= SL && n < SL + GP + 12, 1'b1);
    waitQ();
    gateRun <= 1'b0;
    comparatorOut_n <= 1'b1;
    endTest("stretch");
    bus(1'b1, hsg_pkg::ADDR_CONTROL, 32'h01, 32'h0);
    tickRun <= 1'b1;
    cycle();
    outQ.push_back(5'h10);
    outQ.push_back(5'h00);
    gateRun <= 1'b1;
    waitRise();
    check("dividerDelay", n >= DV && n < DV + GP + 12, 1'b1);
    waitQ();
    gateRun <= 1'b0;
    // Off plug-in, so leaving divider mode cannot restart the scan
    pluginSelected <= 1'b0;
    bus(1'b1, hsg_pkg::ADDR_CONTROL, 32'h0, 32'h0);
    endTest("divider");
    // manual index held; gate stays low until the beat arrives
    idx = 4'h2 + 4'($urandom % 8);
    outQ.push_back({1'b0, idx});
    bus(1'b1, hsg_pkg::ADDR_CONTROL, {24'h0, idx, 4'h2}, 32'h0);
    cycle();
    gateRun <= 1'b1;
    repeat (4 * GP) @(posedge clock);
    outQ.push_back({1'b1, idx});
    outQ.push_back({1'b0, idx});
    comparatorOut_n <= 1'b0;
    waitQ();
    gateRun <= 1'b0;
    tickRun <= 1'b0;
    comparatorOut_n <= 1'b1;
    outQ.push_back(5'h00);
    bus(1'b1, hsg_pkg::ADDR_CONTROL, 32'h0, 32'h0);
    endTest("manual");
    printVerdict();
  end
endmodule : hsg_gate_doubler_tb
`default_nettype wire
